//--- logic/ssb_map.vh
/*
 * register offsets, bit positions and timing constants for the scan status block.
 * assumes inclusion by bare name from the design file of this block.
 */
`ifndef SSB_MAP_VH
`define SSB_MAP_VH
`define SSB_OFS_STATUS      12'h000
`define SSB_OFS_CTRL        12'h004
`define SSB_OFS_IRQ_STAT    12'h008
`define SSB_OFS_IRQ_MASK    12'h00c
`define SSB_OFS_SPECIAL     12'h010
`define SSB_BIT_ONE         0
`define SSB_BIT_FIRST       1
`define SSB_BIT_RETLOSS     2
`define SSB_BIT_PWRRUN      3
`define SSB_BIT_MINUTE      4
`define SSB_BIT_SECOND      5
`define SSB_BIT_TOGGLE      6
`define SSB_BIT_MODE        7
`define SSB_CTRL_RUN        0
`define SSB_CTRL_FREEPORT   1
`define SSB_CTRL_RETLOSS    2
`define SSB_IRQ_SCAN        0
`define SSB_IRQ_MODE        1
`define SSB_IRQ_W           2
`define SSB_CLK_HZ          40000000
`define SSB_HALF_SEC_MS     500
`define SSB_HALF_MIN_S      30
`define SSB_RESP_OKAY       2'b00
`define SSB_RESP_SLVERR     2'b10
`endif

//--- logic/ssb_scan_status.v
/*
 * scan status byte: eight status bits refreshed at each scan end, with an
 * axi4-lite slave for software, a sticky interrupt status/mask pair, and a
 * freeport release output.
 * assumes the scan engine pulses scan_end_i once per scan, one clock wide,
 * and that mode_run_i and powerup_i are synchronous to mclk.
 */
`default_nettype none
`include "ssb_map.vh"

module ssb_scan_status #(
    parameter HALF_SEC_CYC = (`SSB_CLK_HZ / 1000) * `SSB_HALF_SEC_MS,
    parameter HALF_MIN_N   = 2 * `SSB_HALF_MIN_S
) (
    input  wire        mclk,
    input  wire        reset_n,
    input  wire        scan_end_i,
    input  wire        mode_run_i,
    input  wire        powerup_i,
    input  wire [11:0] s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [11:0] s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    output reg  [7:0]  status_byte_o,
    output reg         freeport_en_o,
    output reg         irq_o
);

    // live timebase and scan state
    reg [31:0] sec_cnt_q;
    reg        sec_wave_q;
    reg [7:0]  half_cnt_q;
    reg        min_wave_q;
    reg        first_done_q;
    reg        retloss_pend_q;
    reg        pwr_pend_q;
    reg        toggle_q;
    reg        mode_q;
    reg [7:0]  status_q;
    reg        run_en_q;
    reg        freeport_req_q;
    reg [`SSB_IRQ_W-1:0] irq_stat_q;
    reg [`SSB_IRQ_W-1:0] irq_mask_q;
    reg [`SSB_IRQ_W-1:0] irq_stat_d;
    reg [7:0]  status_d;
    reg        retloss_pend_d;
    reg        pwr_pend_d;

    // write channel holding registers
    reg        aw_have_q;
    reg        w_have_q;
    reg [11:0] wr_addr_q;
    reg [31:0] wdata_q;
    reg [3:0]  wstrb_q;

    wire [11:0] wr_word  = {wr_addr_q[11:2], 2'b00};
    wire        wr_fire  = aw_have_q & w_have_q & ~s_axi_bvalid;
    wire        wr_ctrl  = wr_fire && (wr_word == `SSB_OFS_CTRL) && wstrb_q[0];
    wire        wr_istat = wr_fire && (wr_word == `SSB_OFS_IRQ_STAT) && wstrb_q[0];
    wire        wr_imask = wr_fire && (wr_word == `SSB_OFS_IRQ_MASK) && wstrb_q[0];

    wire sec_tick = (sec_cnt_q == HALF_SEC_CYC - 1);
    wire min_tick = sec_tick && (half_cnt_q == HALF_MIN_N - 1);
    wire mode_fall = mode_q & ~mode_run_i;
    wire [`SSB_IRQ_W-1:0] irq_ev = {mode_fall, scan_end_i};

    // status byte copied into every lane so bit, byte, word and dword reads agree
    wire [31:0] lane_rep;
    genvar      lane;
    generate
        for (lane = 0; lane < 4; lane = lane + 1) begin : g_lane
            assign lane_rep[lane*8 +: 8] = status_q;
        end
    endgenerate

    // free-running half-second divider feeding both square waves
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            sec_cnt_q  <= 32'h0000_0000;
            sec_wave_q <= 1'b0;
            half_cnt_q <= 8'h00;
            min_wave_q <= 1'b0;
        end else begin
            if (sec_tick) begin
                sec_cnt_q  <= 32'h0000_0000;
                sec_wave_q <= ~sec_wave_q;
                if (min_tick) begin
                    half_cnt_q <= 8'h00;
                    min_wave_q <= ~min_wave_q;
                end else begin
                    half_cnt_q <= half_cnt_q + 8'h01;
                end
            end else begin
                sec_cnt_q <= sec_cnt_q + 32'h0000_0001;
            end
        end
    end

    // pending flags: a request or power-up in the scan-end cycle beats the clear
    always @* begin
        retloss_pend_d = retloss_pend_q;
        pwr_pend_d     = pwr_pend_q;
        if (scan_end_i) begin
            retloss_pend_d = 1'b0;
            if (run_en_q) begin
                pwr_pend_d = 1'b0;
            end
        end
        if (wr_ctrl && wdata_q[`SSB_CTRL_RETLOSS]) begin
            retloss_pend_d = 1'b1;
        end
        if (powerup_i) begin
            pwr_pend_d = 1'b1;
        end
    end

    // the byte the program sees is a snapshot, so the waves change only at scan end
    always @* begin
        status_d = status_q;
        if (scan_end_i) begin
            status_d[`SSB_BIT_ONE]     = 1'b1;
            status_d[`SSB_BIT_FIRST]   = ~first_done_q;
            status_d[`SSB_BIT_RETLOSS] = retloss_pend_q;
            status_d[`SSB_BIT_PWRRUN]  = pwr_pend_q & run_en_q;
            status_d[`SSB_BIT_MINUTE]  = min_wave_q;
            status_d[`SSB_BIT_SECOND]  = sec_wave_q;
            status_d[`SSB_BIT_TOGGLE]  = ~toggle_q;
            status_d[`SSB_BIT_MODE]    = mode_run_i;
        end
    end

    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            first_done_q   <= 1'b0;
            pwr_pend_q     <= 1'b1;
            retloss_pend_q <= 1'b0;
            toggle_q       <= 1'b0;
            mode_q         <= 1'b0;
            status_q       <= 8'h01;
        end else begin
            mode_q         <= mode_run_i;
            pwr_pend_q     <= pwr_pend_d;
            retloss_pend_q <= retloss_pend_d;
            status_q       <= status_d;
            if (scan_end_i) begin
                first_done_q <= 1'b1;
                toggle_q     <= ~toggle_q;
            end
        end
    end

    // write channel: address and data taken in either order
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            aw_have_q     <= 1'b0;
            w_have_q      <= 1'b0;
            wr_addr_q     <= 12'h000;
            wdata_q       <= 32'h0000_0000;
            wstrb_q       <= 4'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `SSB_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q     <= 1'b1;
                wr_addr_q     <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q     <= 1'b1;
                wdata_q      <= s_axi_wdata;
                wstrb_q      <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire) begin
                aw_have_q    <= 1'b0;
                w_have_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                case (wr_word)
                    `SSB_OFS_STATUS,
                    `SSB_OFS_SPECIAL:  s_axi_bresp <= `SSB_RESP_OKAY;
                    `SSB_OFS_CTRL,
                    `SSB_OFS_IRQ_STAT,
                    `SSB_OFS_IRQ_MASK: s_axi_bresp <= `SSB_RESP_OKAY;
                    default:           s_axi_bresp <= `SSB_RESP_SLVERR;
                endcase
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // hardware set beats a software clear in the same cycle
    always @* begin
        irq_stat_d = irq_stat_q;
        if (wr_istat) begin
            irq_stat_d = irq_stat_d & ~wdata_q[`SSB_IRQ_W-1:0];
        end
        irq_stat_d = irq_stat_d | irq_ev;
    end

    // control, freeport and interrupt state; a hardware set beats a clear
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            run_en_q       <= 1'b0;
            freeport_req_q <= 1'b0;
            freeport_en_o  <= 1'b0;
            irq_stat_q     <= {`SSB_IRQ_W{1'b0}};
            irq_mask_q     <= {`SSB_IRQ_W{1'b0}};
            irq_o          <= 1'b0;
            status_byte_o  <= 8'h01;
        end else begin
            if (wr_ctrl) begin
                run_en_q       <= wdata_q[`SSB_CTRL_RUN];
                freeport_req_q <= wdata_q[`SSB_CTRL_FREEPORT];
            end
            // freeport only holds while the switch is in run
            if (!mode_run_i)
                freeport_en_o <= 1'b0;
            else
                freeport_en_o <= freeport_req_q;
            if (mode_fall && !wr_ctrl)
                freeport_req_q <= 1'b0;
            if (wr_imask)
                irq_mask_q <= wdata_q[`SSB_IRQ_W-1:0];
            irq_stat_q    <= irq_stat_d;
            irq_o         <= |(irq_stat_q & irq_mask_q);
            status_byte_o <= status_q;
        end
    end

    // read channel; status byte replicated at the special offset so any width or lane sees it, lane 0 only at the status offset
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `SSB_RESP_OKAY;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rresp   <= `SSB_RESP_OKAY;
                case ({s_axi_araddr[11:2], 2'b00})
                    `SSB_OFS_STATUS:   s_axi_rdata <= {24'h000000, status_q};
                    `SSB_OFS_SPECIAL:  s_axi_rdata <= lane_rep;
                    `SSB_OFS_CTRL:     s_axi_rdata <= {29'h0, retloss_pend_q,
                                                   freeport_req_q, run_en_q};
                    `SSB_OFS_IRQ_STAT: s_axi_rdata <= {30'h0, irq_stat_q};
                    `SSB_OFS_IRQ_MASK: s_axi_rdata <= {30'h0, irq_mask_q};
                    default: begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= `SSB_RESP_SLVERR;
                    end
                endcase
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

endmodule // ssb_scan_status
`default_nettype wire

//--- bench/ssb_scan_status_sva.sv
/* assertions on the scan status block ports: refresh timing, flags, read answer.
   assumes a bind onto ssb_scan_status, one clock, reset_n active low. */
`default_nettype none
module ssb_scan_status_sva (
    input wire logic       mclk,
    input wire logic       reset_n,
    input wire logic       scan_end_i,
    input wire logic       mode_run_i,
    input wire logic       s_axi_arvalid,
    input wire logic       s_axi_arready,
    input wire logic       s_axi_rvalid,
    input wire logic [7:0] status_byte_o,
    input wire logic       freeport_en_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    one_bit_a: assert property (status_byte_o[0])
        else $error("constant bit low");
    // output copy lags the scan end by two edges
    refresh_only_a: assert property (!$past(scan_end_i, 2) |-> $stable(status_byte_o))
        else $error("status byte moved without scan end");
    toggle_bit_a: assert property ($past(scan_end_i, 2) |-> status_byte_o[6] != $past(status_byte_o[6]))
        else $error("toggle bit did not invert");
    mode_bit_a: assert property ($past(scan_end_i, 2) |-> status_byte_o[7] == $past(mode_run_i, 2))
        else $error("mode bit wrong");
    first_once_a: assert property ($past(scan_end_i, 2) && $past(status_byte_o[1]) |-> !status_byte_o[1])
        else $error("first scan flag held");
    retloss_once_a: assert property ($past(scan_end_i, 2) && $past(status_byte_o[2]) |-> !status_byte_o[2])
        else $error("retentive loss flag held");
    pwrrun_once_a: assert property ($past(scan_end_i, 2) && $past(status_byte_o[3]) |-> !status_byte_o[3])
        else $error("powerup run flag held");
    freeport_end_a: assert property ($fell(mode_run_i) |-> ##[1:3] !freeport_en_o)
        else $error("freeport not released");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
endmodule // ssb_scan_status_sva
`default_nettype wire

//--- bench/ssb_scan_status_test.sv
/* self-checking bench for the scan status block, random mode per scan in the twelve later scans.
   assumes the design with short wave counts and the checker bound below. */
`default_nettype none
module ssb_scan_status_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk, reset_n, se, mr, pu, awv, wv, br, arv, rr, tog, m;
    logic        awr, wrdy, bv, arr, rv, fp, irq;
    logic [11:0] awa, ara;
    logic [31:0] wd, rdat;
    logic [3:0]  ws;
    logic [1:0]  bresp, rresp;
    logic [7:0]  sb;
    int          fails, num_checks;
    ssb_scan_status #(.HALF_SEC_CYC(10), .HALF_MIN_N(4)) dut (
        .mclk(mclk), .reset_n(reset_n), .scan_end_i(se), .mode_run_i(mr), .powerup_i(pu),
        .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
        .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_bresp(bresp),
        .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
        .s_axi_rready(rr), .status_byte_o(sb), .freeport_en_o(fp), .irq_o(irq));
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    function automatic logic [7:0] eb(input logic md, t, p, r, f);
        eb = {md, t, 2'b00, p, r, f, 1'b1};
    endfunction
    task automatic summarize;
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] g, e);
        num_checks++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic tmo(input int n);
        if (n >= 40) begin
            fails++;
            $display("[FAIL] handshake exp done got timeout");
            summarize();
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        logic ka, kw;
        awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1;
        ka = 0; kw = 0; n = 0;
        do begin
            @(posedge mclk);
            n++;
            if (awr) begin awv <= 1'b0; ka = 1; end
            if (wrdy) begin wv <= 1'b0; kw = 1; end
        end while (!(ka && kw) && n < 40);
        br <= 1'b1;
        do begin @(posedge mclk); n++; end while (!bv && n < 40);
        r = bresp;
        br <= 1'b0;
        tmo(n);
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        ara <= a; arv <= 1'b1; n = 0;
        do begin @(posedge mclk); n++; end while (!arr && n < 40);
        arv <= 1'b0; rr <= 1'b1;
        do begin @(posedge mclk); n++; end while (!rv && n < 40);
        d = rdat; r = rresp;
        rr <= 1'b0;
        tmo(n);
    endtask
    task automatic scan;
        se <= 1'b1;
        @(posedge mclk);
        se <= 1'b0;
        tog = ~tog;
        repeat (3) @(posedge mclk);
    endtask
    initial begin
        logic [31:0] d;
        logic [1:0]  r;
        int          c4, c5;
        {se, mr, pu, awv, wv, br, arv, rr, tog} = '0;
        awa = '0; ara = '0; wd = '0; ws = 4'hf; reset_n = 1'b0; fails = 0; num_checks = 0;
        void'($urandom(32'he72ea13c));
        repeat (16) @(posedge mclk);
        chk("reset byte", sb, 8'h01);
        reset_n <= 1'b1;
        mr <= 1'b1;
        @(posedge mclk);
        wr(12'h00c, 32'h1, r);
        wr(12'h004, 32'h5, r);
        scan();
        chk("first scan", sb & 8'hcf, eb(1, tog, 1, 1, 1));
        chk("irq raised", irq, 1);
        rd(12'h010, d, r);
        chk("all lanes", d & 32'hcfcfcfcf, {4{eb(1, tog, 1, 1, 1)}});
        wr(12'h000, 32'h0, r);
        chk("write resp", r, 2'b00);
        rd(12'h000, d, r);
        chk("write ignored", d[7:0] & 8'hcf, eb(1, tog, 1, 1, 1));
        wr(12'h008, 32'h1, r);
        repeat (2) @(posedge mclk);
        chk("irq cleared", irq, 0);
        rd(12'h020, d, r);
        chk("unmapped resp", r, 2'b10);
        chk("unmapped data", d, 32'h0);
        repeat (12) begin
            m = 1'($urandom % 2);
            mr <= m;
            scan();
            chk("later scan", sb & 8'hcf, eb(m, tog, 0, 0, 0));
        end
        mr <= 1'b1;
        wr(12'h004, 32'h3, r);
        repeat (2) @(posedge mclk);
        chk("freeport on", fp, 1);
        mr <= 1'b0;
        repeat (3) @(posedge mclk);
        chk("freeport off", fp, 0);
        mr <= 1'b1;
        pu <= 1'b1;
        @(posedge mclk);
        pu <= 1'b0;
        scan();
        chk("powerup run", sb & 8'hcf, eb(1, tog, 1, 0, 0));
        scan();
        chk("powerup once", sb & 8'hcf, eb(1, tog, 0, 0, 0));
        c4 = 0;
        c5 = 0;
        // five cycles per sample against 10 and 40 cycle half periods
        repeat (40) begin
            scan();
            @(posedge mclk);
            c4 += int'(sb[4]);
            c5 += int'(sb[5]);
        end
        chk("second wave", c5 >= 18 && c5 <= 22, 1);
        chk("minute wave", c4 >= 15 && c4 <= 25, 1);
        summarize();
    end
endmodule // ssb_scan_status_test
bind ssb_scan_status ssb_scan_status_sva u_sva (.mclk(mclk), .reset_n(reset_n),
    .scan_end_i(scan_end_i), .mode_run_i(mode_run_i), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
    .status_byte_o(status_byte_o), .freeport_en_o(freeport_en_o));
`default_nettype wire
